/* inc/bcs_regs.vh */
// Register offsets, field positions, reset values and timing constants for the converter register bank.
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
`define BCS_ADDR_SW_UV     8'h03
`define BCS_ADDR_C1_VOUT   8'h46
`define BCS_ADDR_C1_MODE   8'h47
`define BCS_ADDR_C1_OVPR   8'h48
`define BCS_ADDR_C1_BO     8'h49
`define BCS_ADDR_C2_VOUT   8'h4a
`define BCS_ADDR_C2_MODE   8'h4b
`define BCS_ADDR_C2_OVPR   8'h4c
`define BCS_ADDR_C2_BO     8'h4d
`define BCS_ADDR_C3_VOUT   8'h4e
`define BCS_ADDR_C3_MODE   8'h4f
`define BCS_ADDR_C3_OVPR   8'h50
`define BCS_ADDR_C3_BO     8'h51
`define BCS_ADDR_C3_LPV    8'h52
`define BCS_RST_SW_UV      3'h0
`define BCS_RST_C1_VOUT    8'hc0
`define BCS_RST_C2_VOUT    8'h78
`define BCS_RST_C3_VOUT    8'h50
`define BCS_RST_C12_MODE   8'h40
`define BCS_RST_C3_MODE    8'h24
`define BCS_RST_C12_OVPR   8'h46
`define BCS_RST_C3_OVPR    8'h06
`define BCS_RST_C12_BO     8'h49
`define BCS_RST_C3_BO      8'h59
`define BCS_RST_C3_LPV     7'h37
`define BCS_LOW_NIBBLE     8'h0f
`define BCS_LPV_MASK       8'h7f
`define BCS_SW_UV_MASK     8'h07
`define BCS_BIT_FPWM       0
`define BCS_BIT_ADDIS      1
`define BCS_BIT_FSREN      2
`define BCS_BIT_OVTHR      0
`define BCS_BIT_PR_LO      1
`define BCS_BIT_HYS_LO     0
`define BCS_BIT_BOTHR_LO   2
`define BCS_C12_BASE_UV    24'd600000
`define BCS_C12_STEP_NV    24'd6250000
`define BCS_C3_BASE_UV     24'd260000
`define BCS_C3_STEP_NV     24'd10000000
`define BCS_OV_LO_PM       11'd1083
`define BCS_OV_HI_PM       11'd1166
`define BCS_PWM_HOLD_NS    32'd50000
`define BCS_CLK_PERIOD_NS  32'd8
`endif

/* hw/bcs_conv_cfg.v */
// Per-converter decoder of the configuration fields into analog control settings.
`timescale 1ns/100ps
`include "bcs_regs.vh"
module bcs_conv_cfg #(
    parameter [23:0] BASE_UV = `BCS_C12_BASE_UV,
    parameter [23:0] STEP_NV = `BCS_C12_STEP_NV
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // Register contents.
    input  wire [7:0]  vout_code,
    input  wire [7:0]  mode_reg,
    input  wire [7:0]  ovpr_reg,
    input  wire [7:0]  bo_reg,
    // Converter status.
    input  wire        conv_enabled,
    // Decoded settings.
    output reg  [23:0] target_uv,
    output reg         discharge_on,
    output reg         skip_allowed,
    output reg  [1:0]  reject_speed,
    output reg  [10:0] ov_thr_permille,
    output reg  [6:0]  bo_fall_pct,
    output reg  [4:0]  bo_hys_pct
);
    // Linear code-to-voltage transfer, the step held in nanovolts.
    function [23:0] code_to_uv;
        input [7:0]  code;
        input [23:0] base;
        input [23:0] step;
        reg   [31:0] prod;
        begin
            prod       = code * step / 32'd1000;
            code_to_uv = base + prod[23:0];
        end
    endfunction

    // Falling threshold lookup.
    function [6:0] fall_pct;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    fall_pct = 7'd77;
                2'h1:    fall_pct = 7'd81;
                2'h2:    fall_pct = 7'd86;
                default: fall_pct = 7'd91;
            endcase
        end
    endfunction

    // Settings are registered so the analog side sees clean levels.
    always @(posedge clk)
    begin
        if (rst)
        begin
            target_uv       <= 24'h000000;
            discharge_on    <= 1'b0;
            skip_allowed    <= 1'b0;
            reject_speed    <= 2'h0;
            ov_thr_permille <= `BCS_OV_LO_PM;
            bo_fall_pct     <= 7'd77;
            bo_hys_pct      <= 5'd5;
        end
        else
        begin
            target_uv       <= code_to_uv(vout_code, BASE_UV, STEP_NV);
            discharge_on    <= ~mode_reg[`BCS_BIT_ADDIS] & ~conv_enabled;
            skip_allowed    <= ~mode_reg[`BCS_BIT_FPWM];
            reject_speed    <= ovpr_reg[`BCS_BIT_PR_LO +: 2];
            ov_thr_permille <= ovpr_reg[`BCS_BIT_OVTHR] ? `BCS_OV_HI_PM : `BCS_OV_LO_PM;
            bo_fall_pct     <= fall_pct(bo_reg[`BCS_BIT_BOTHR_LO +: 2]);
            bo_hys_pct      <= {1'b0, bo_reg[`BCS_BIT_HYS_LO +: 2], 2'b00}
                               + {3'b000, bo_reg[`BCS_BIT_HYS_LO +: 2]} + 5'd5;
        end
    end
endmodule // bcs_conv_cfg

/* hw/bcs_pwm_hold.v */
// Falling-slew forced PWM control with a hold time after the output settles.
`timescale 1ns/100ps
`include "bcs_regs.vh"
module bcs_pwm_hold #(
    parameter HOLD_CYCLES = (`BCS_PWM_HOLD_NS + `BCS_CLK_PERIOD_NS - 32'd1) / `BCS_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire clk,
    input  wire rst,
    // Controls.
    input  wire fsren,
    input  wire fpwm_en,
    input  wire falling,
    // Result.
    output reg  force_pwm
);
    reg [31:0] hold_cnt;

    // Forces PWM while falling and counts the hold once the output reaches target.
    always @(posedge clk)
    begin
        if (rst)
        begin
            hold_cnt  <= 32'h00000000;
            force_pwm <= 1'b0;
        end
        else if (fpwm_en)
        begin
            hold_cnt  <= 32'h00000000;
            force_pwm <= 1'b1;
        end
        else if (fsren && falling)
        begin
            hold_cnt  <= HOLD_CYCLES;
            force_pwm <= 1'b1;
        end
        else if (hold_cnt != 32'h00000000)
        begin
            hold_cnt  <= hold_cnt - 32'd1;
            force_pwm <= 1'b1;
        end
        else
        begin
            force_pwm <= 1'b0;
        end
    end
endmodule // bcs_pwm_hold

/* hw/bcs_bank.v */
// Register bank for three step-down converters and the load-switch undervoltage flags.
//
// Contract
// - Converters one and two: target is 0.6 V plus code times 6.25 mV.
// - Converter three: target is 0.26 V plus code times 10 mV.
// - Bits seven to four of mode, threshold, brownout registers store nothing.
// - Converter three: falling-slew discharge on forces PWM while falling, held 50 us after.
// - Discharge off allows skipping while falling only if forced PWM off.
// - Discharge resistor connects when converter off unless disable bit set.
// - Forced PWM bit zero allows pulse skipping; one forces fixed frequency.
// - Two-bit pulse rejection field picks fast to slow response.
// - Overvoltage select picks 108.3 or 116.6 percent threshold.
// - Brownout falling threshold codes give 77, 81, 86, 91 percent.
// - Brownout hysteresis codes give 5, 10, 15, 20 percent.
// - Low-power code is seven bits, same transfer; zero is reserved.
// - Switch undervoltage flag sets when enabled and low, clears on read.
`timescale 1ns/100ps
`include "bcs_regs.vh"
module bcs_bank #(
    parameter HOLD_CYCLES = (`BCS_PWM_HOLD_NS + `BCS_CLK_PERIOD_NS - 32'd1) / `BCS_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // Register access port from the serial slave.
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Converter status from the analog side.
    input  wire [2:0]  conv_enabled,
    input  wire        conv3_falling,
    input  wire        low_power_mode,
    // Load switch status.
    input  wire [2:0]  switch_enabled,
    input  wire [2:0]  switch_below_uv,
    // Converter one settings.
    output wire [23:0] conv1_target_uv,
    output wire        conv1_discharge_on,
    output wire        conv1_skip_allowed,
    output wire [1:0]  conv1_reject_speed,
    output wire [10:0] conv1_ov_permille,
    output wire [6:0]  conv1_bo_fall_pct,
    output wire [4:0]  conv1_bo_hys_pct,
    // Converter two settings.
    output wire [23:0] conv2_target_uv,
    output wire        conv2_discharge_on,
    output wire        conv2_skip_allowed,
    output wire [1:0]  conv2_reject_speed,
    output wire [10:0] conv2_ov_permille,
    output wire [6:0]  conv2_bo_fall_pct,
    output wire [4:0]  conv2_bo_hys_pct,
    // Converter three settings.
    output wire [23:0] conv3_target_uv,
    output wire        conv3_discharge_on,
    output reg         conv3_skip_allowed,
    output wire [1:0]  conv3_reject_speed,
    output wire [10:0] conv3_ov_permille,
    output wire [6:0]  conv3_bo_fall_pct,
    output wire [4:0]  conv3_bo_hys_pct,
    output reg         conv3_lp_code_bad,
    // Undervoltage flags.
    output reg  [2:0]  switch_uv_flags
);
    // Stored registers, then combinational read and flag values and internal nets.
    reg  [7:0] conv1_voltage_setting;
    reg  [3:0] conv1_mode_discharge_cfg;
    reg  [3:0] conv1_overvolt_reject_cfg;
    reg  [3:0] conv1_brownout_cfg;
    reg  [7:0] conv2_voltage_setting;
    reg  [3:0] conv2_mode_discharge_cfg;
    reg  [3:0] conv2_overvolt_reject_cfg;
    reg  [3:0] conv2_brownout_cfg;
    reg  [7:0] conv3_voltage_setting;
    reg  [3:0] conv3_mode_discharge_cfg;
    reg  [3:0] conv3_overvolt_reject_cfg;
    reg  [3:0] conv3_brownout_cfg;
    reg  [6:0] low_power_voltage_code;
    reg  [7:0] next_rdata;
    reg  [2:0] next_flags;
    wire       force_pwm3;
    wire       skip3_raw;
    wire [7:0] active_vout3;
    wire       rd_flags;

    // Keeps the stored low nibble of a reset value whose upper bits have no storage.
    function [3:0] lo_nib;
        input [7:0] value;
        begin
            lo_nib = value[3:0];
        end
    endfunction

    // Low-power mode swaps in the seven-bit code, same transfer.
    assign active_vout3 = low_power_mode ? {1'b0, low_power_voltage_code} : conv3_voltage_setting;
    assign rd_flags     = reg_rd && (reg_addr == `BCS_ADDR_SW_UV);

    // Register writes; upper nibbles of the mixed registers have no storage.
    always @(posedge clk)
    begin
        if (rst)
        begin
            conv1_voltage_setting     <= `BCS_RST_C1_VOUT;
            conv1_mode_discharge_cfg  <= lo_nib(`BCS_RST_C12_MODE);
            conv1_overvolt_reject_cfg <= lo_nib(`BCS_RST_C12_OVPR);
            conv1_brownout_cfg        <= lo_nib(`BCS_RST_C12_BO);
            conv2_voltage_setting     <= `BCS_RST_C2_VOUT;
            conv2_mode_discharge_cfg  <= lo_nib(`BCS_RST_C12_MODE);
            conv2_overvolt_reject_cfg <= lo_nib(`BCS_RST_C12_OVPR);
            conv2_brownout_cfg        <= lo_nib(`BCS_RST_C12_BO);
            conv3_voltage_setting     <= `BCS_RST_C3_VOUT;
            conv3_mode_discharge_cfg  <= lo_nib(`BCS_RST_C3_MODE);
            conv3_overvolt_reject_cfg <= lo_nib(`BCS_RST_C3_OVPR);
            conv3_brownout_cfg        <= lo_nib(`BCS_RST_C3_BO);
            low_power_voltage_code    <= `BCS_RST_C3_LPV;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `BCS_ADDR_C1_VOUT: conv1_voltage_setting     <= reg_wdata;
                `BCS_ADDR_C1_MODE: conv1_mode_discharge_cfg  <= reg_wdata[3:0];
                `BCS_ADDR_C1_OVPR: conv1_overvolt_reject_cfg <= reg_wdata[3:0];
                `BCS_ADDR_C1_BO:   conv1_brownout_cfg        <= reg_wdata[3:0];
                `BCS_ADDR_C2_VOUT: conv2_voltage_setting     <= reg_wdata;
                `BCS_ADDR_C2_MODE: conv2_mode_discharge_cfg  <= reg_wdata[3:0];
                `BCS_ADDR_C2_OVPR: conv2_overvolt_reject_cfg <= reg_wdata[3:0];
                `BCS_ADDR_C2_BO:   conv2_brownout_cfg        <= reg_wdata[3:0];
                `BCS_ADDR_C3_VOUT: conv3_voltage_setting     <= reg_wdata;
                `BCS_ADDR_C3_MODE: conv3_mode_discharge_cfg  <= reg_wdata[3:0];
                `BCS_ADDR_C3_OVPR: conv3_overvolt_reject_cfg <= reg_wdata[3:0];
                `BCS_ADDR_C3_BO:   conv3_brownout_cfg        <= reg_wdata[3:0];
                `BCS_ADDR_C3_LPV:  low_power_voltage_code    <= reg_wdata[6:0];
                default:           conv1_voltage_setting     <= conv1_voltage_setting;
            endcase
        end
    end

    // Read multiplexer; absent bits and unmapped addresses read zero.
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `BCS_ADDR_SW_UV:   next_rdata = {5'h00, switch_uv_flags};
            `BCS_ADDR_C1_VOUT: next_rdata = conv1_voltage_setting;
            `BCS_ADDR_C1_MODE: next_rdata = {4'h0, conv1_mode_discharge_cfg};
            `BCS_ADDR_C1_OVPR: next_rdata = {4'h0, conv1_overvolt_reject_cfg};
            `BCS_ADDR_C1_BO:   next_rdata = {4'h0, conv1_brownout_cfg};
            `BCS_ADDR_C2_VOUT: next_rdata = conv2_voltage_setting;
            `BCS_ADDR_C2_MODE: next_rdata = {4'h0, conv2_mode_discharge_cfg};
            `BCS_ADDR_C2_OVPR: next_rdata = {4'h0, conv2_overvolt_reject_cfg};
            `BCS_ADDR_C2_BO:   next_rdata = {4'h0, conv2_brownout_cfg};
            `BCS_ADDR_C3_VOUT: next_rdata = conv3_voltage_setting;
            `BCS_ADDR_C3_MODE: next_rdata = {4'h0, conv3_mode_discharge_cfg};
            `BCS_ADDR_C3_OVPR: next_rdata = {4'h0, conv3_overvolt_reject_cfg};
            `BCS_ADDR_C3_BO:   next_rdata = {4'h0, conv3_brownout_cfg};
            `BCS_ADDR_C3_LPV:  next_rdata = {1'b0, low_power_voltage_code};
            default:           next_rdata = 8'h00;
        endcase
    end

    // Flag update: a new event outranks the clear of a read in the same cycle.
    always @*
    begin
        next_flags = rd_flags ? 3'h0 : switch_uv_flags;
        next_flags = next_flags | (switch_enabled & switch_below_uv);
        next_flags = next_flags & switch_enabled;
    end

    // Read data, flags and converter three mode outputs.
    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata          <= 8'h00;
            reg_rvalid         <= 1'b0;
            switch_uv_flags    <= `BCS_RST_SW_UV;
            conv3_skip_allowed <= 1'b0;
            conv3_lp_code_bad  <= 1'b0;
        end
        else
        begin
            reg_rdata          <= reg_rd ? next_rdata : 8'h00;
            reg_rvalid         <= reg_rd;
            switch_uv_flags    <= next_flags;
            conv3_skip_allowed <= skip3_raw & ~force_pwm3;
            conv3_lp_code_bad  <= (low_power_voltage_code == 7'h00);
        end
    end

    // Converter one decode.
    bcs_conv_cfg #(.BASE_UV(`BCS_C12_BASE_UV), .STEP_NV(`BCS_C12_STEP_NV)) u_conv1 (
        .clk             (clk),
        .rst             (rst),
        .vout_code       (conv1_voltage_setting),
        .mode_reg        ({4'h0, conv1_mode_discharge_cfg}),
        .ovpr_reg        ({4'h0, conv1_overvolt_reject_cfg}),
        .bo_reg          ({4'h0, conv1_brownout_cfg}),
        .conv_enabled    (conv_enabled[0]),
        .target_uv       (conv1_target_uv),
        .discharge_on    (conv1_discharge_on),
        .skip_allowed    (conv1_skip_allowed),
        .reject_speed    (conv1_reject_speed),
        .ov_thr_permille (conv1_ov_permille),
        .bo_fall_pct     (conv1_bo_fall_pct),
        .bo_hys_pct      (conv1_bo_hys_pct)
    );

    // Converter two decode.
    bcs_conv_cfg #(.BASE_UV(`BCS_C12_BASE_UV), .STEP_NV(`BCS_C12_STEP_NV)) u_conv2 (
        .clk             (clk),
        .rst             (rst),
        .vout_code       (conv2_voltage_setting),
        .mode_reg        ({4'h0, conv2_mode_discharge_cfg}),
        .ovpr_reg        ({4'h0, conv2_overvolt_reject_cfg}),
        .bo_reg          ({4'h0, conv2_brownout_cfg}),
        .conv_enabled    (conv_enabled[1]),
        .target_uv       (conv2_target_uv),
        .discharge_on    (conv2_discharge_on),
        .skip_allowed    (conv2_skip_allowed),
        .reject_speed    (conv2_reject_speed),
        .ov_thr_permille (conv2_ov_permille),
        .bo_fall_pct     (conv2_bo_fall_pct),
        .bo_hys_pct      (conv2_bo_hys_pct)
    );

    // Converter three decode, using the active voltage code.
    bcs_conv_cfg #(.BASE_UV(`BCS_C3_BASE_UV), .STEP_NV(`BCS_C3_STEP_NV)) u_conv3 (
        .clk             (clk),
        .rst             (rst),
        .vout_code       (active_vout3),
        .mode_reg        ({4'h0, conv3_mode_discharge_cfg}),
        .ovpr_reg        ({4'h0, conv3_overvolt_reject_cfg}),
        .bo_reg          ({4'h0, conv3_brownout_cfg}),
        .conv_enabled    (conv_enabled[2]),
        .target_uv       (conv3_target_uv),
        .discharge_on    (conv3_discharge_on),
        .skip_allowed    (skip3_raw),
        .reject_speed    (conv3_reject_speed),
        .ov_thr_permille (conv3_ov_permille),
        .bo_fall_pct     (conv3_bo_fall_pct),
        .bo_hys_pct      (conv3_bo_hys_pct)
    );

    // Converter three falling-slew PWM hold.
    bcs_pwm_hold #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold3 (
        .clk       (clk),
        .rst       (rst),
        .fsren     (conv3_mode_discharge_cfg[`BCS_BIT_FSREN]),
        .fpwm_en   (conv3_mode_discharge_cfg[`BCS_BIT_FPWM]),
        .falling   (conv3_falling),
        .force_pwm (force_pwm3)
    );
endmodule // bcs_bank

/* testbench/bcs_bank_properties.sv */
// Concurrent checks on the ports of the converter register bank.
`timescale 1ns/100ps
module bcs_bank_properties (
    // Clock and reset.
    input wire        clk,
    input wire        rst,
    // Register access.
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire [7:0]  reg_wdata,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire        reg_rvalid,
    // Status inputs.
    input wire [2:0]  conv_enabled,
    input wire        low_power_mode,
    input wire [2:0]  switch_enabled,
    input wire [2:0]  switch_below_uv,
    // Observed settings.
    input wire [23:0] conv1_target_uv,
    input wire [23:0] conv3_target_uv,
    input wire        conv1_discharge_on,
    input wire        conv1_skip_allowed,
    input wire [1:0]  conv1_reject_speed,
    input wire [10:0] conv1_ov_permille,
    input wire [2:0]  switch_uv_flags
);
    // All checks share the single clock and the synchronous reset.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Writes to the converter one and three registers and the flag read; a lone write settles two edges later.
    wire wr_c1_vout = reg_wr && reg_addr == 8'h46;
    wire wr_c1_mode = reg_wr && reg_addr == 8'h47;
    wire wr_c1_ovpr = reg_wr && reg_addr == 8'h48;
    wire wr_c3_vout = reg_wr && reg_addr == 8'h4e;
    wire rd_flags   = reg_rd && reg_addr == 8'h03;
    c1_target_a: assert property (wr_c1_vout ##1 !wr_c1_vout |=>
        conv1_target_uv == 24'd600000 + $past(reg_wdata, 2) * 24'd6250) else $error("converter one target wrong");
    c3_target_a: assert property (wr_c3_vout ##1 (!wr_c3_vout && !low_power_mode) |=>
        conv3_target_uv == 24'd260000 + $past(reg_wdata, 2) * 24'd10000) else $error("converter three target wrong");
    discharge_off_a: assert property (conv_enabled[0] |=> !conv1_discharge_on)
        else $error("discharge resistor on while converter enabled");
    skip_mode_a: assert property (wr_c1_mode ##1 !wr_c1_mode |=> conv1_skip_allowed == !$past(reg_wdata[0], 2))
        else $error("skip permission does not follow forced pwm bit");
    reject_sel_a: assert property (wr_c1_ovpr ##1 !wr_c1_ovpr |=> conv1_reject_speed == $past(reg_wdata[2:1], 2))
        else $error("pulse rejection setting wrong");
    ov_select_a: assert property (wr_c1_ovpr ##1 !wr_c1_ovpr |=>
        conv1_ov_permille == ($past(reg_wdata[0], 2) ? 11'd1166 : 11'd1083)) else $error("overvoltage threshold wrong");
    flag_set_a: assert property (switch_enabled[0] && switch_below_uv[0] |=> switch_uv_flags[0])
        else $error("undervoltage flag not set");
    flag_off_a: assert property (!switch_enabled[2] |=> !switch_uv_flags[2])
        else $error("flag set while switch disabled");
    flag_read_a: assert property (rd_flags |=> reg_rvalid && reg_rdata == {5'h00, $past(switch_uv_flags)})
        else $error("flag read returned wrong value");
    read_race_a: assert property (rd_flags && switch_enabled[1] && switch_below_uv[1] |=> switch_uv_flags[1])
        else $error("new event lost to clear on read");
endmodule // bcs_bank_properties

bind bcs_bank bcs_bank_properties u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_enabled(conv_enabled), .low_power_mode(low_power_mode), .switch_enabled(switch_enabled),
    .switch_below_uv(switch_below_uv), .conv1_target_uv(conv1_target_uv), .conv3_target_uv(conv3_target_uv),
    .conv1_discharge_on(conv1_discharge_on), .conv1_skip_allowed(conv1_skip_allowed),
    .conv1_reject_speed(conv1_reject_speed), .conv1_ov_permille(conv1_ov_permille),
    .switch_uv_flags(switch_uv_flags));

/* testbench/bcs_host.sv */
// Register host model issuing single-byte reads and writes on the strobe port.
`timescale 1ns/100ps
module bcs_host (
    // Clock.
    input  wire       clk,
    // Access strobes toward the bank.
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    // Read answer.
    input  wire [7:0] reg_rdata,
    input  wire       reg_rvalid
);
    // Bus idles with no strobe.
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One write held across one taking edge; released data is inverted so it never looks current.
    task wr(input [7:0] addr, input [7:0] data);
    begin
        @(negedge clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~data;
    end
    endtask
    // One read; the answer stands in the cycle after the taking edge.
    task rd(input [7:0] addr, output [8:0] got);
    begin
        @(negedge clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk);
        got = {reg_rvalid, reg_rdata};
        reg_rd = 1'b0;
        reg_addr = ~addr;
    end
    endtask
endmodule // bcs_host

/* testbench/buck_config_and_switch_flags_test.sv */
// Self-checking testbench for the converter register bank.
`timescale 1ns/100ps
module buck_config_and_switch_flags_test;
    localparam HOLD = 10;
    localparam [119:0] ADDRS = 120'h60_52_51_50_4f_4e_4d_4c_4b_4a_49_48_47_46_03;
    localparam [119:0] RSTV  = 120'h00_37_59_06_24_50_49_46_40_78_49_46_40_c0_00;
    localparam [119:0] MASK  = 120'h00_7f_0f_0f_0f_ff_0f_0f_0f_ff_0f_0f_0f_ff_00;
    localparam [27:0]  FALL  = {7'd91, 7'd86, 7'd81, 7'd77};
    reg         clk, rst, conv3_falling, low_power_mode;
    reg  [2:0]  conv_enabled, switch_enabled, switch_below_uv;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, reg_rvalid, c1_dis, c3_dis, c1_skip, c3_skip, lp_bad;
    wire [23:0] c1_uv, c2_uv, c3_uv;
    wire [1:0]  c1_rej;
    wire [10:0] c1_ov, c2_ov;
    wire [6:0]  c1_fall;
    wire [4:0]  c1_hys;
    wire [2:0]  switch_uv_flags;
    reg  [8:0]  got;
    integer     num_errors, checked, cycles, i;
    // Design and host model.
    bcs_bank #(.HOLD_CYCLES(HOLD)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .conv_enabled(conv_enabled), .conv3_falling(conv3_falling), .low_power_mode(low_power_mode),
        .switch_enabled(switch_enabled), .switch_below_uv(switch_below_uv), .conv1_target_uv(c1_uv),
        .conv1_discharge_on(c1_dis), .conv1_skip_allowed(c1_skip), .conv1_reject_speed(c1_rej),
        .conv1_ov_permille(c1_ov), .conv1_bo_fall_pct(c1_fall), .conv1_bo_hys_pct(c1_hys),
        .conv2_target_uv(c2_uv), .conv2_discharge_on(), .conv2_skip_allowed(), .conv2_reject_speed(),
        .conv2_ov_permille(c2_ov), .conv2_bo_fall_pct(), .conv2_bo_hys_pct(), .conv3_target_uv(c3_uv),
        .conv3_discharge_on(c3_dis), .conv3_skip_allowed(c3_skip), .conv3_reject_speed(), .conv3_ov_permille(),
        .conv3_bo_fall_pct(), .conv3_bo_hys_pct(), .conv3_lp_code_bad(lp_bad), .switch_uv_flags(switch_uv_flags));
    bcs_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    // Clock and hang guard.
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            num_errors = num_errors + 1;
            results;
        end
    end
    task chk(input [31:0] val, input [31:0] exp);
    begin
        checked = checked + 1;
        if (val !== exp)
            $display("unexpected at %0t: got %h expected %h", $time, val, exp);
        if (val !== exp)
            num_errors = num_errors + 1;
    end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Reset values, storage width and ignored writes of every register and one unmapped place.
    task t_regs;
    begin
        for (i = 0; i < 15; i = i + 1)
        begin
            u_host.rd(ADDRS[i*8 +: 8], got);
            chk(got, {1'b1, RSTV[i*8 +: 8] & MASK[i*8 +: 8]});
            u_host.wr(ADDRS[i*8 +: 8], 8'hff);
            u_host.rd(ADDRS[i*8 +: 8], got);
            chk(got, {1'b1, MASK[i*8 +: 8]});
        end
    end
    endtask
    // Voltage codes, the top end of the range, and the low-power code.
    task t_volt;
    begin
        u_host.wr(8'h46, 8'h10);
        u_host.wr(8'h4a, 8'hff);
        u_host.wr(8'h4e, 8'h7c);
        tick(3);
        chk(c1_uv, 700000);
        chk(c2_uv, 2193750);
        chk(c3_uv, 1500000);
        chk(c2_ov, 1166);
        low_power_mode = 1'b1;
        u_host.wr(8'h52, 8'h7f);
        tick(3);
        chk(c3_uv, 1530000);
        chk(lp_bad, 0);
        u_host.wr(8'h52, 8'h00);
        tick(3);
        chk(lp_bad, 1);
        low_power_mode = 1'b0;
        u_host.wr(8'h52, 8'h37);
    end
    endtask
    // Discharge resistor, forced PWM, and the falling-slew hold of converter three.
    task t_modes;
    begin
        u_host.wr(8'h47, 8'h00);
        tick(3);
        chk(c1_dis, 1);
        chk(c1_skip, 1);
        conv_enabled = 3'b001;
        tick(2);
        chk(c1_dis, 0);
        conv_enabled = 3'b000;
        u_host.wr(8'h47, 8'h03);
        tick(3);
        chk(c1_dis, 0);
        chk(c1_skip, 0);
        conv3_falling = 1'b1;
        u_host.wr(8'h4f, 8'h00);
        tick(4);
        chk(c3_skip, 1);
        chk(c3_dis, 1);
        u_host.wr(8'h4f, 8'h01);
        tick(4);
        chk(c3_skip, 0);
        u_host.wr(8'h4f, 8'h04);
        tick(4);
        chk(c3_skip, 0);
        conv3_falling = 1'b0;
        tick(HOLD - 3);
        chk(c3_skip, 0);
        tick(6);
        chk(c3_skip, 1);
    end
    endtask
    // Every code of the rejection, overvoltage, falling threshold and hysteresis fields.
    task t_thresh;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            u_host.wr(8'h48, {4'h0, 1'b0, i[1:0], i[0]});
            u_host.wr(8'h49, {4'h0, i[1:0], i[1:0]});
            tick(3);
            chk(c1_rej, i);
            chk(c1_ov, i[0] ? 1166 : 1083);
            chk(c1_fall, FALL[i*7 +: 7]);
            chk(c1_hys, 5 * (i + 1));
        end
        u_host.wr(8'h48, 8'h07);
    end
    endtask
    // Flag setting, clear on read, an event racing a read, and a disabled switch.
    task t_flags;
    begin
        switch_enabled = 3'b111;
        switch_below_uv = 3'b101;
        tick(1);
        switch_below_uv = 3'b000;
        tick(1);
        chk(switch_uv_flags, 3'b101);
        u_host.rd(8'h03, got);
        chk(got, 9'h105);
        chk(switch_uv_flags, 3'b000);
        fork
            u_host.rd(8'h03, got);
            begin
                @(negedge clk);
                switch_below_uv = 3'b010;
                @(negedge clk);
                switch_below_uv = 3'b000;
            end
        join
        chk(got, 9'h100);
        chk(switch_uv_flags, 3'b010);
        switch_below_uv = 3'b100;
        tick(2);
        switch_enabled = 3'b011;
        tick(2);
        chk(switch_uv_flags, 3'b010);
        u_host.rd(8'h03, got);
        chk(got, 9'h102);
    end
    endtask
    task results;
    begin
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Reset for five cycles, then run each scenario.
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        conv3_falling = 1'b0;
        low_power_mode = 1'b0;
        conv_enabled = 3'b000;
        switch_enabled = 3'b000;
        switch_below_uv = 3'b000;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        tick(5);
        rst = 1'b0;
        t_regs;
        t_volt;
        t_modes;
        t_thresh;
        t_flags;
        results;
    end
endmodule // buck_config_and_switch_flags_test
